// ==== rtl/ipab_consts.svh ====
`ifndef IPAB_CONSTS_SVH
`define IPAB_CONSTS_SVH
// register offsets on the plain register port
`define IPAB_OFF_PRIO_A 5'h00
`define IPAB_OFF_PRIO_B 5'h01
`define IPAB_OFF_PRIO_C 5'h02
`define IPAB_OFF_PRIO_D 5'h03
`define IPAB_OFF_BRK_CTL 5'h04
`define IPAB_OFF_BAR_H 5'h05
`define IPAB_OFF_BAR_M 5'h06
`define IPAB_OFF_BAR_L 5'h07
`define IPAB_OFF_CFG 5'h08
`define IPAB_OFF_SENSE_3 5'h09
`define IPAB_OFF_SENSE_2 5'h0A
`define IPAB_OFF_SENSE_1 5'h0B
`define IPAB_OFF_SENSE_0 5'h0C
`define IPAB_OFF_EN_H 5'h0D
`define IPAB_OFF_EN_L 5'h0E
`define IPAB_OFF_PSEL_H 5'h0F
`define IPAB_OFF_PSEL_L 5'h10
`define IPAB_OFF_DTC_H 5'h11
`define IPAB_OFF_DTC_L 5'h12
`define IPAB_OFF_STATUS 5'h13
// field positions
`define IPAB_BIE_BIT 0
`define IPAB_CMF_BIT 7
`define IPAB_CFG_MODE_HI 7
`define IPAB_CFG_MODE_LO 6
`define IPAB_CFG_DTC_ALSO 1
`define IPAB_CFG_NMI_RISE 0
`define IPAB_CFG_MASK 8'hC3
// reset value of every register
`define IPAB_RST_BYTE 8'h00
// requests fed only from the alternate pins
`define IPAB_ALT_ONLY 16'h3300
// source indexes
`define IPAB_SRC_BRK 6'h1F
`define IPAB_SRC_NMI 6'h20
`define IPAB_SRC_NONE 6'h3F
// vector numbers
`define IPAB_VEC_NMI 8'h07
`define IPAB_VEC_IRQ_LO 8'h10
`define IPAB_VEC_IRQ_HI 8'h30
`define IPAB_VEC_INT 8'h12
`define IPAB_VEC_BRK 8'h18
`endif

// ==== rtl/ipab_pkg.sv ====
package ipab_pkg;
	// sense codes of one external request
	typedef enum logic [1:0] {
		IPAB_SENSE_LOW = 2'b00,
		IPAB_SENSE_FALL = 2'b01,
		IPAB_SENSE_RISE = 2'b10,
		IPAB_SENSE_BOTH = 2'b11
	} ipab_sense_t;
	// interrupt control modes
	typedef enum logic [1:0] {
		IPAB_MODE0 = 2'b00,
		IPAB_MODE1 = 2'b10
	} ipab_mode_t;
	// whole state of the controller
	typedef struct packed {
		logic [7:0] prio_a;
		logic [7:0] prio_b;
		logic [7:0] prio_c;
		logic [7:0] prio_d;
		logic condition_match_flag;
		logic break_enable;
		logic [7:0] bar_h;
		logic [7:0] bar_m;
		logic [7:1] bar_l;
		logic [7:0] cfg;
		logic [31:0] sense;
		logic [15:0] en;
		logic [15:0] pinsel;
		logic [15:0] dtcen;
		logic [15:0] pin_prev;
		logic [15:0] eflag;
		logic nmi_prev;
		logic nmi_flag;
		logic [5:0] src;
		logic cpu_req;
		logic dtc_req;
		logic brk_req;
		logic [7:0] vec;
		logic [7:0] rdata;
	} ipab_state_t;
endpackage

// ==== rtl/ipab_top.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "ipab_consts.svh"
// Function
// - two control modes from mode bits
// - per-module priority bit, one means priority
// - three-level masking from mode, I, UI
// - every source gets its own vector
// - nonmaskable request always wins, always accepted
// - nonmaskable input rising or falling edge
// - per-request low, fall, rise, both sensing
// - choose primary or alternate request pin, requests 8, 9, 12, 13 alternate only
// - request may start transfer controller
// - priority A and D source map
// - priority B and C source map
// - break request while match and enable
// - match flag sets on prefetch address hit while break enable is set
// - match flag clears on break exception
// - break enable bit zero, resets low
// - break control bits six..one read zero
// - high break byte versus address 23..16
// - mid break byte versus address 15..8
// - low break bits 7..1, bit0 zero
// - sense codes 00 low, 01 fall, 10 rise, 11 both
// - separate enables gate requests 15..0
module ipab_top
	import ipab_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	// register port
	input wire logic [4:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// external request pins
	input wire logic nmi_pin,
	input wire logic [15:0] primary_request_pin,
	input wire logic [15:0] alternate_request_pin,
	// peripheral requests, held high until served
	input wire logic [14:0] periph_req,
	// processor side
	input wire logic ccr_i_mask,
	input wire logic user_mask_bit,
	input wire logic [23:0] prefetch_addr,
	input wire logic prefetch_valid,
	input wire logic cpu_ack,
	output logic cpu_req,
	output logic [7:0] cpu_vector,
	output logic break_req,
	// data transfer controller
	input wire logic dtc_ack,
	output logic dtc_req
);

	ipab_state_t s_q;
	ipab_state_t s_d;
	logic [15:0] pin_sel;
	logic [15:0] evt;
	logic [15:0] lvl_req;
	logic [31:0] req;
	logic [31:0] lvl;
	logic ack;
	logic nmi_evt;
	logic match;
	logic mode1;
	logic allow_p;
	logic allow_np;
	logic found;
	logic [5:0] win;

	////////////////////////////////////////////////////////////////////////
	// priority bit of each source
	function automatic logic lvl_of(input logic [5:0] i,
		input ipab_state_t s);
		case (i)
		6'h00: lvl_of = s.prio_a[7];
		6'h01: lvl_of = s.prio_a[6];
		6'h02, 6'h03: lvl_of = s.prio_a[5];
		6'h04, 6'h05: lvl_of = s.prio_a[4];
		6'h06, 6'h07: lvl_of = s.prio_a[3];
		6'h08, 6'h09, 6'h0A, 6'h0B: lvl_of = s.prio_d[7];
		6'h0C, 6'h0D, 6'h0E, 6'h0F: lvl_of = s.prio_d[6];
		6'h10: lvl_of = s.prio_a[2];
		6'h11: lvl_of = s.prio_a[1];
		6'h12: lvl_of = s.prio_a[0];
		6'h13: lvl_of = s.prio_b[7];
		6'h14: lvl_of = s.prio_b[6];
		6'h15: lvl_of = s.prio_b[4];
		6'h16: lvl_of = s.prio_b[3];
		6'h17: lvl_of = s.prio_b[2];
		6'h18: lvl_of = s.prio_b[1];
		6'h19: lvl_of = s.prio_c[7];
		6'h1A: lvl_of = s.prio_c[6];
		6'h1B: lvl_of = s.prio_c[4];
		6'h1C: lvl_of = s.prio_c[3];
		6'h1D: lvl_of = s.prio_c[2];
		6'h1E: lvl_of = s.prio_c[1];
		default: lvl_of = 1'b1;
		endcase
	endfunction

	// vector number of each source
	function automatic logic [7:0] vec_of(input logic [5:0] i);
		if (i == `IPAB_SRC_NMI)
			vec_of = `IPAB_VEC_NMI;
		else if (i == `IPAB_SRC_BRK)
			vec_of = `IPAB_VEC_BRK;
		else if (i < 6'h08)
			vec_of = `IPAB_VEC_IRQ_LO + {2'h0, i};
		else if (i < 6'h10)
			vec_of = `IPAB_VEC_IRQ_HI + {2'h0, i};
		else
			vec_of = `IPAB_VEC_INT + {2'h0, i};
	endfunction

	////////////////////////////////////////////////////////////////////////
	// per-request pin choice and sensing
	// requests that can only take the alternate pin
	localparam logic [15:0] alt_only = `IPAB_ALT_ONLY;
	genvar g;
	generate
		for (g = 0; g < 16; g++)
		begin : g_irq
			logic [1:0] code;
			logic fall;
			logic rise;
			assign pin_sel[g] = (s_q.pinsel[g] | alt_only[g]) ?
				alternate_request_pin[g] : primary_request_pin[g];
			assign code = s_q.sense[2*g +: 2];
			assign fall = s_q.pin_prev[g] & ~pin_sel[g];
			assign rise = ~s_q.pin_prev[g] & pin_sel[g];
			// edge events per sense code
			assign evt[g] = (code == IPAB_SENSE_FALL & fall) |
				(code == IPAB_SENSE_RISE & rise) |
				(code == IPAB_SENSE_BOTH & (fall | rise));
			assign lvl_req[g] = (code == IPAB_SENSE_LOW) & ~pin_sel[g];
		end
	endgenerate

	// break address compare, address bit 0 left out
	assign match = prefetch_valid & s_q.break_enable &
		({s_q.bar_h, s_q.bar_m, s_q.bar_l} == prefetch_addr[23:1]);
	assign mode1 = ipab_mode_t'(s_q.cfg[7:6]) == IPAB_MODE1;
	// three-level mask
	assign allow_np = ~ccr_i_mask;
	assign allow_p = ~ccr_i_mask | (mode1 & ~user_mask_bit);
	assign ack = (cpu_ack & s_q.cpu_req) | (dtc_ack & s_q.dtc_req);
	assign nmi_evt = s_q.cfg[`IPAB_CFG_NMI_RISE] ?
		(~s_q.nmi_prev & nmi_pin) : (s_q.nmi_prev & ~nmi_pin);

	////////////////////////////////////////////////////////////////////////
	// next state
	always_comb
	begin
		s_d = s_q;
		// register writes
		if (reg_wr)
		begin
			case (reg_addr)
			`IPAB_OFF_PRIO_A: s_d.prio_a = reg_wdata;
			`IPAB_OFF_PRIO_B: s_d.prio_b = reg_wdata;
			`IPAB_OFF_PRIO_C: s_d.prio_c = reg_wdata;
			`IPAB_OFF_PRIO_D: s_d.prio_d = reg_wdata;
			`IPAB_OFF_BRK_CTL: s_d.break_enable = reg_wdata[`IPAB_BIE_BIT];
			`IPAB_OFF_BAR_H: s_d.bar_h = reg_wdata;
			`IPAB_OFF_BAR_M: s_d.bar_m = reg_wdata;
			`IPAB_OFF_BAR_L: s_d.bar_l = reg_wdata[7:1];
			`IPAB_OFF_CFG: s_d.cfg = reg_wdata & `IPAB_CFG_MASK;
			`IPAB_OFF_SENSE_3: s_d.sense[31:24] = reg_wdata;
			`IPAB_OFF_SENSE_2: s_d.sense[23:16] = reg_wdata;
			`IPAB_OFF_SENSE_1: s_d.sense[15:8] = reg_wdata;
			`IPAB_OFF_SENSE_0: s_d.sense[7:0] = reg_wdata;
			`IPAB_OFF_EN_H: s_d.en[15:8] = reg_wdata;
			`IPAB_OFF_EN_L: s_d.en[7:0] = reg_wdata;
			`IPAB_OFF_PSEL_H: s_d.pinsel[15:8] = reg_wdata;
			`IPAB_OFF_PSEL_L: s_d.pinsel[7:0] = reg_wdata;
			`IPAB_OFF_DTC_H: s_d.dtcen[15:8] = reg_wdata;
			`IPAB_OFF_DTC_L: s_d.dtcen[7:0] = reg_wdata;
			default: ;
			endcase
		end
		// read data for the next cycle, zero otherwise
		s_d.rdata = `IPAB_RST_BYTE;
		if (reg_rd)
		begin
			case (reg_addr)
			`IPAB_OFF_PRIO_A: s_d.rdata = s_q.prio_a;
			`IPAB_OFF_PRIO_B: s_d.rdata = s_q.prio_b;
			`IPAB_OFF_PRIO_C: s_d.rdata = s_q.prio_c;
			`IPAB_OFF_PRIO_D: s_d.rdata = s_q.prio_d;
			`IPAB_OFF_BRK_CTL: s_d.rdata = {s_q.condition_match_flag, 6'h00, s_q.break_enable};
			`IPAB_OFF_BAR_H: s_d.rdata = s_q.bar_h;
			`IPAB_OFF_BAR_M: s_d.rdata = s_q.bar_m;
			`IPAB_OFF_BAR_L: s_d.rdata = {s_q.bar_l, 1'b0};
			`IPAB_OFF_CFG: s_d.rdata = s_q.cfg;
			`IPAB_OFF_SENSE_3: s_d.rdata = s_q.sense[31:24];
			`IPAB_OFF_SENSE_2: s_d.rdata = s_q.sense[23:16];
			`IPAB_OFF_SENSE_1: s_d.rdata = s_q.sense[15:8];
			`IPAB_OFF_SENSE_0: s_d.rdata = s_q.sense[7:0];
			`IPAB_OFF_EN_H: s_d.rdata = s_q.en[15:8];
			`IPAB_OFF_EN_L: s_d.rdata = s_q.en[7:0];
			`IPAB_OFF_PSEL_H: s_d.rdata = s_q.pinsel[15:8];
			`IPAB_OFF_PSEL_L: s_d.rdata = s_q.pinsel[7:0];
			`IPAB_OFF_DTC_H: s_d.rdata = s_q.dtcen[15:8];
			`IPAB_OFF_DTC_L: s_d.rdata = s_q.dtcen[7:0];
			`IPAB_OFF_STATUS: s_d.rdata = {s_q.cpu_req, s_q.dtc_req, s_q.src};
			default: s_d.rdata = `IPAB_RST_BYTE;
			endcase
		end
		// pin history for edge detection
		s_d.pin_prev = pin_sel;
		s_d.nmi_prev = nmi_pin;
		// acknowledge clears the served flag first
		if (ack && s_q.src < 6'h10)
			s_d.eflag[s_q.src[3:0]] = 1'b0;
		if (ack && s_q.src == `IPAB_SRC_NMI)
			s_d.nmi_flag = 1'b0;
		if (cpu_ack && s_q.cpu_req && s_q.src == `IPAB_SRC_BRK)
			s_d.condition_match_flag = 1'b0;
		// new events win over the clear
		s_d.eflag = s_d.eflag | evt;
		if (nmi_evt)
			s_d.nmi_flag = 1'b1;
		if (match)
			s_d.condition_match_flag = 1'b1;
		// pending requests by source index
		req = {s_d.condition_match_flag & s_d.break_enable, periph_req,
			(s_d.eflag | lvl_req) & s_q.en};
		for (int i = 0; i < 32; i++)
			lvl[i] = lvl_of(6'(i), s_q);
		// priority level first, lowest index wins
		found = 1'b0;
		win = `IPAB_SRC_NONE;
		for (int i = 31; i >= 0; i--)
		begin
			if (req[i] && lvl[i] && allow_p)
			begin
				win = 6'(i);
				found = 1'b1;
			end
		end
		// then non-priority level
		if (!found)
		begin
			for (int i = 31; i >= 0; i--)
			begin
				if (req[i] && !lvl[i] && allow_np)
				begin
					win = 6'(i);
					found = 1'b1;
				end
			end
		end
		// nonmaskable request overrides all masks
		if (s_d.nmi_flag)
		begin
			win = `IPAB_SRC_NMI;
			found = 1'b1;
		end
		s_d.src = win;
		s_d.vec = found ? vec_of(win) : `IPAB_RST_BYTE;
		// transfer controller instead of or beside the processor
		if (found && win < 6'h10 && s_q.dtcen[win[3:0]])
		begin
			s_d.dtc_req = 1'b1;
			s_d.cpu_req = s_q.cfg[`IPAB_CFG_DTC_ALSO];
		end
		else
		begin
			s_d.dtc_req = 1'b0;
			s_d.cpu_req = found;
		end
		s_d.brk_req = s_d.condition_match_flag & s_d.break_enable;
	end

	// state register, all zero after reset
	always_ff @(posedge clk)
	begin
		if (!resetn)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	// outputs straight from flip-flops
	assign reg_rdata = s_q.rdata;
	assign cpu_req = s_q.cpu_req;
	assign cpu_vector = s_q.vec;
	assign break_req = s_q.brk_req;
	assign dtc_req = s_q.dtc_req;

	////////////////////////////////////////////////////////////////////////
	// checks
	a_nmi_always_wins: assert property (@(posedge clk) disable iff (!resetn)
		s_q.nmi_flag |-> cpu_req && cpu_vector == `IPAB_VEC_NMI)
		else $error("nmi pending but not presented");

	a_nmi_edge_seen: assert property (@(posedge clk) disable iff (!resetn)
		s_q.cfg[`IPAB_CFG_NMI_RISE] && !s_q.nmi_prev && nmi_pin
		|=> s_q.nmi_flag ##0 cpu_vector == `IPAB_VEC_NMI)
		else $error("nmi rising edge lost");

	a_mask_all: assert property (@(posedge clk) disable iff (!resetn)
		cpu_req && cpu_vector != `IPAB_VEC_NMI
		|-> !$past(ccr_i_mask) || $past(mode1))
		else $error("maskable request passed global mask in mode 0");

	a_fall_flag: assert property (@(posedge clk) disable iff (!resetn)
		s_q.sense[1:0] == IPAB_SENSE_FALL && s_q.pin_prev[0] && !pin_sel[0]
		|=> s_q.eflag[0])
		else $error("falling edge on request 0 lost");

	a_cmf_set: assert property (@(posedge clk) disable iff (!resetn)
		prefetch_valid && s_q.break_enable &&
		prefetch_addr[23:1] == {s_q.bar_h, s_q.bar_m, s_q.bar_l}
		|=> s_q.condition_match_flag ##0 break_req)
		else $error("break address match not flagged");

	a_brk_cause: assert property (@(posedge clk) disable iff (!resetn)
		$rose(break_req) |-> $past(s_q.break_enable) && $past(prefetch_valid))
		else $error("break request without enabled prefetch");

	a_cmf_clear: assert property (@(posedge clk) disable iff (!resetn)
		cpu_ack && cpu_req && s_q.src == `IPAB_SRC_BRK && !match
		|=> !s_q.condition_match_flag && !break_req)
		else $error("match flag not cleared by break exception");

	a_bie_write: assert property (@(posedge clk) disable iff (!resetn)
		reg_wr && reg_addr == `IPAB_OFF_BRK_CTL
		|=> s_q.break_enable == $past(reg_wdata[0]))
		else $error("break enable write not taken");

	a_rsv_zero: assert property (@(posedge clk) disable iff (!resetn)
		reg_rd && reg_addr == `IPAB_OFF_BRK_CTL |=> reg_rdata[6:1] == 6'h00)
		else $error("break control reserved bits not zero");

	a_barl_bit0: assert property (@(posedge clk) disable iff (!resetn)
		reg_rd && reg_addr == `IPAB_OFF_BAR_L |=> !reg_rdata[0])
		else $error("low break address bit 0 not zero");

	a_cmf_read_only: assert property (@(posedge clk) disable iff (!resetn)
		reg_wr && reg_addr == `IPAB_OFF_BRK_CTL && !s_q.condition_match_flag && !match
		|=> !s_q.condition_match_flag)
		else $error("match flag set by a register write");

	a_barl_write: assert property (@(posedge clk) disable iff (!resetn)
		reg_wr && reg_addr == `IPAB_OFF_BAR_L
		|=> s_q.bar_l == $past(reg_wdata[7:1]))
		else $error("low break address write not taken");

	a_reset_clear: assert property (@(posedge clk)
		!resetn |=> s_q.prio_a == 8'h00 && s_q.prio_d == 8'h00 &&
		!s_q.break_enable && s_q.bar_h == 8'h00 && s_q.bar_l == 7'h00)
		else $error("register not back at reset value");

	a_dtc_only: assert property (@(posedge clk) disable iff (!resetn)
		dtc_req && !$past(s_q.cfg[`IPAB_CFG_DTC_ALSO])
		|-> !cpu_req)
		else $error("processor asked although transfer controller only");

	a_en_gate: assert property (@(posedge clk) disable iff (!resetn)
		cpu_req && cpu_vector == `IPAB_VEC_IRQ_LO + 8'h02
		|-> $past(s_q.en[2]))
		else $error("disabled request 2 presented");

	a_nmi_fall_seen: assert property (@(posedge clk) disable iff (!resetn)
		!s_q.cfg[`IPAB_CFG_NMI_RISE] && s_q.nmi_prev && !nmi_pin
		|=> s_q.nmi_flag)
		else $error("nmi falling edge lost");

endmodule
`default_nettype wire

// ==== tb/ipab_cpu_model.sv ====
`timescale 1ns/1ns
`default_nettype none
////////////////////////////////////////////////////////////////////////////
// processor and transfer controller side, answers after a random delay
module ipab_cpu_model
(
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	// bench control, hold blocks every answer
	input wire logic hold,
	input wire logic [1:0] delay,
	// requests and answers
	input wire logic cpu_req,
	input wire logic [7:0] cpu_vector,
	input wire logic dtc_req,
	output logic cpu_ack,
	output logic dtc_ack,
	output logic [7:0] last_vec
);
	logic [1:0] wait_q;
	// one-cycle ack of a standing request, never two in a row
	always_ff @(posedge clk)
	begin
		cpu_ack <= 1'b0;
		dtc_ack <= 1'b0;
		if (!resetn)
		begin
			wait_q <= 2'h0;
			last_vec <= 8'h00;
		end
		else if (!hold && !cpu_ack && !dtc_ack)
		begin
			if (cpu_req && wait_q == delay)
			begin
				cpu_ack <= 1'b1;
				last_vec <= cpu_vector; // taken with the ack
			end
			else if (dtc_req && wait_q == delay)
				dtc_ack <= 1'b1;
			wait_q <= (cpu_req || dtc_req) && wait_q != delay ? wait_q + 2'h1 : 2'h0;
		end
	end
endmodule
`default_nettype wire

// ==== tb/ipab_top_tb.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "ipab_consts.svh"
////////////////////////////////////////////////////////////////////////////
module ipab_top_tb;
	logic clk, resetn, reg_wr, reg_rd, nmi_pin, ccr_i_mask, user_mask_bit;
	logic prefetch_valid, cpu_ack, cpu_req, break_req, dtc_ack, dtc_req, hold;
	logic [4:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata, cpu_vector, last_vec, r, v;
	logic [15:0] primary_request_pin, alternate_request_pin;
	logic [14:0] periph_req;
	logic [23:0] prefetch_addr, ba;
	logic [1:0] delay;
	logic e;
	logic [7:0] pmask [4] = '{8'hFF, 8'hDE, 8'hDE, 8'hC0};
	logic [23:0] flip [5] = '{24'h000001, 24'h010000, 24'h000100, 24'h000002, 24'h000001};
	int num_errors = 0, n_compared = 0, cyc = 0, seed, i, c, n;
	////////////////////////////////////////////////////////////////////////
	ipab_top ipab_top_i (.clk(clk), .resetn(resetn), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .nmi_pin(nmi_pin),
		.primary_request_pin(primary_request_pin),
		.alternate_request_pin(alternate_request_pin), .periph_req(periph_req),
		.ccr_i_mask(ccr_i_mask), .user_mask_bit(user_mask_bit),
		.prefetch_addr(prefetch_addr), .prefetch_valid(prefetch_valid),
		.cpu_ack(cpu_ack), .cpu_req(cpu_req), .cpu_vector(cpu_vector),
		.break_req(break_req), .dtc_ack(dtc_ack), .dtc_req(dtc_req));
	ipab_cpu_model ipab_cpu_model_i (.clk(clk), .resetn(resetn), .hold(hold),
		.delay(delay), .cpu_req(cpu_req), .cpu_vector(cpu_vector),
		.dtc_req(dtc_req), .cpu_ack(cpu_ack), .dtc_ack(dtc_ack),
		.last_vec(last_vec));
	////////////////////////////////////////////////////////////////////////
	// clock and hang guard
	always #2 clk = ~clk;
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			num_errors++;
			results();
		end
	end
	// vector number of an external request
	function automatic logic [7:0] irq_vec(input int k);
		irq_vec = k < 8 ? `IPAB_VEC_IRQ_LO + k[7:0] : `IPAB_VEC_IRQ_HI + k[7:0];
	endfunction
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic results();
		$display("compared %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic tick(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask
	// register port, one-cycle strobes
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [4:0] a, output logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask
	task automatic rst();
		@(posedge clk);
		resetn <= 1'b0;
		repeat (8) @(posedge clk);
		resetn <= 1'b1;
	endtask
	// fresh start: one sense code everywhere, all enabled, alternate pins
	task automatic setup(input logic [1:0] s);
		rst();
		hold <= 1'b1;
		for (int k = 9; k < 13; k++)
			wr(k[4:0], {4{s}});
		for (int k = 13; k < 17; k++)
			wr(k[4:0], 8'hFF);
	endtask
	// let the far side answer everything pending
	task automatic drain();
		delay <= 2'($random(seed));
		hold <= 1'b0;
		tick(12);
		hold <= 1'b1;
		tick(2);
	endtask
	////////////////////////////////////////////////////////////////////////
	initial
	begin
		seed = 2;
		{clk, resetn, reg_wr, reg_rd, nmi_pin, ccr_i_mask, user_mask_bit} = 7'h00;
		{prefetch_valid, reg_addr, reg_wdata, periph_req, prefetch_addr} = '0;
		{primary_request_pin, alternate_request_pin} = 32'hFFFFFFFF;
		hold = 1'b1;
		delay = 2'h0;
		rst();
		// reset values, access kinds, unmapped place
		for (i = 0; i < 9; i++)
		begin
			rd(i[4:0], r);
			chk(r, `IPAB_RST_BYTE);
		end
		for (i = 0; i < 8; i++)
		begin
			v = 8'($random(seed));
			if (i < 4)
				v = v & pmask[i];
			wr(i[4:0], v);
			rd(i[4:0], r);
			chk(r, i == 4 ? {7'h00, v[0]} : i == 7 ? v & 8'hFE : v);
		end
		wr(5'h1F, 8'hFF);
		rd(5'h1F, r);
		chk(r, 8'h00);
		// every sense code, primary pin deselected
		for (c = 0; c < 4; c++)
		begin
			n = $unsigned($random(seed)) % 16;
			setup(c[1:0]);
			@(posedge clk) primary_request_pin[n] <= 1'b0;
			tick(3);
			chk(cpu_req, 1'b0);
			@(posedge clk) primary_request_pin[n] <= 1'b1;
			@(posedge clk) alternate_request_pin[n] <= 1'b0;
			tick(3);
			chk(cpu_vector, c == 2 ? 8'h00 : irq_vec(n));
			drain();
			@(posedge clk) alternate_request_pin[n] <= 1'b1;
			tick(3);
			chk(cpu_vector, c[1] ? irq_vec(n) : 8'h00);
			drain();
		end
		// primary pin chosen for request 1, alternate ignored then
		wr(`IPAB_OFF_PSEL_L, 8'h00);
		@(posedge clk) alternate_request_pin[1] <= 1'b0;
		tick(3);
		chk(cpu_req, 1'b0);
		@(posedge clk) primary_request_pin[1] <= 1'b0;
		tick(3);
		chk(cpu_vector, irq_vec(1));
		@(posedge clk) {primary_request_pin[1], alternate_request_pin[1]} <= 2'b11;
		drain();
		// masking over mode, global mask, user mask, priority bit
		setup(2'b01);
		@(posedge clk) alternate_request_pin[0] <= 1'b0;
		for (i = 0; i < 16; i++)
		begin
			wr(`IPAB_OFF_CFG, {i[3], 7'h00});
			wr(`IPAB_OFF_PRIO_A, {i[0], 7'h00});
			ccr_i_mask <= i[2];
			user_mask_bit <= i[1];
			tick(3);
			e = i[3] ? (!i[2] || (!i[1] && i[0])) : !i[2];
			chk(cpu_req, e);
			chk(cpu_vector, e ? irq_vec(0) : 8'h00);
		end
		// nonmaskable request on both edges, everything else masked
		for (i = 0; i < 2; i++)
		begin
			wr(`IPAB_OFF_CFG, {1'b1, 6'h00, !i[0]});
			@(posedge clk) nmi_pin <= !i[0];
			tick(3);
			chk(cpu_vector, `IPAB_VEC_NMI);
			drain();
		end
		chk(last_vec, `IPAB_VEC_NMI);
		chk(cpu_req, 1'b0);
		@(posedge clk) alternate_request_pin[0] <= 1'b1;
		// enable gating, fixed order, priority level
		setup(2'b01);
		ccr_i_mask <= 1'b0;
		wr(`IPAB_OFF_EN_L, 8'hFB);
		@(posedge clk) alternate_request_pin <= 16'hFFDB;
		tick(3);
		chk(cpu_vector, irq_vec(5));
		wr(`IPAB_OFF_EN_L, 8'hFF);
		tick(2);
		chk(cpu_vector, irq_vec(2));
		wr(`IPAB_OFF_PRIO_B, 8'h80);
		periph_req[3] <= 1'b1;
		tick(3);
		chk(cpu_vector, 8'h25);
		wr(`IPAB_OFF_PRIO_A, 8'h20);
		tick(2);
		chk(cpu_vector, irq_vec(2));
		@(posedge clk) periph_req[3] <= 1'b0;
		alternate_request_pin <= 16'hFFFF;
		drain();
		// transfer controller instead of, then beside, the processor
		setup(2'b01);
		wr(`IPAB_OFF_DTC_L, 8'h01);
		@(posedge clk) alternate_request_pin <= 16'hFFFE;
		tick(3);
		chk({cpu_req, dtc_req}, 8'h01);
		wr(`IPAB_OFF_CFG, 8'h02);
		tick(2);
		chk({cpu_req, dtc_req}, 8'h03);
		rd(`IPAB_OFF_STATUS, r);
		chk(r, 8'hC0);
		@(posedge clk) alternate_request_pin <= 16'hFFFF;
		drain();
		chk(dtc_req, 1'b0);
		// address break: disabled, misses per byte and bit, then a hit
		setup(2'b01);
		ba = 24'($random(seed)) & 24'hFFFFFE;
		wr(`IPAB_OFF_BAR_H, ba[23:16]);
		wr(`IPAB_OFF_BAR_M, ba[15:8]);
		wr(`IPAB_OFF_BAR_L, ba[7:0]);
		for (i = 0; i < 5; i++)
		begin
			wr(`IPAB_OFF_BRK_CTL, {7'h00, i != 0});
			@(posedge clk) prefetch_addr <= ba ^ flip[i];
			prefetch_valid <= 1'b1;
			@(posedge clk) prefetch_valid <= 1'b0;
			tick(3);
			chk(break_req, i == 4);
			rd(`IPAB_OFF_BRK_CTL, r);
			chk(r, {i == 4, 6'h00, i != 0});
		end
		chk(cpu_vector, `IPAB_VEC_BRK);
		drain();
		chk(last_vec, `IPAB_VEC_BRK);
		chk(break_req, 1'b0);
		results();
	end
endmodule
`default_nettype wire
